/* rtl/cpd_pkg.sv */
// constants and helpers for the process data link
package cpd_pkg;
  localparam int NODE_W         = 7;
  localparam int CFG_W          = 6;
  localparam int BAUD_LSB       = 0;
  localparam int PD_LSB         = 2;
  localparam int IO_EN_BIT      = 4;
  localparam int RSVD_BIT       = 5;
  localparam int BYTE_W         = 8;
  localparam int WORD_W         = 16;
  localparam int MAX_WORDS      = 3;
  localparam int LEN_W          = 4;
  localparam int SYNC_STAGES    = 2;
  localparam logic [6:0] NODE_INVALID = 7'h00;
  localparam logic [1:0] BAUD_125K    = 2'h0;
  localparam logic [1:0] BAUD_250K    = 2'h1;
  localparam logic [1:0] BAUD_500K    = 2'h2;
  localparam logic [1:0] BAUD_1M      = 2'h3;
  localparam logic [1:0] PD_CODE_0    = 2'h0;
  localparam logic [1:0] PD_CODE_BAD  = 2'h1;
  localparam logic [1:0] PD_CODE_2    = 2'h2;
  localparam logic [1:0] PD_CODE_3    = 2'h3;
  localparam int CLK_KHZ         = 200000;
  localparam int FLASH_PERIOD_MS = 1000;
  localparam int FLASH_HALF_CYC  = FLASH_PERIOD_MS * CLK_KHZ / 2;

  typedef enum logic [1:0] {CPD_ST_SYNC, CPD_ST_FAULT, CPD_ST_PREOP, CPD_ST_OPER} cpd_state_t;

  function automatic logic [1:0] cpd_words(input logic [1:0] code);
    cpd_words = (code == PD_CODE_3) ? 2'h3 : (code == PD_CODE_2) ? 2'h2 : 2'h0;
  endfunction

  // byte count with appended I/O byte
  function automatic logic [LEN_W-1:0] cpd_len(input logic [1:0] words, input logic io);
    cpd_len = LEN_W'({words, 1'b0}) + LEN_W'(io);
  endfunction

  // byte k of a frame, low byte first
  function automatic logic [7:0] cpd_pick(input logic [LEN_W-1:0] k,
                                           input logic [1:0] words,
                                           input logic [47:0] w,
                                           input logic [7:0] io);
    if (k < LEN_W'({words, 1'b0}))
      cpd_pick = w[{k[2:1], 4'h0} + {k[0], 3'h0} +: 8];
    else
      cpd_pick = io;
  endfunction
endpackage

/* rtl/cpd_link_if.sv */
// byte link between bus master end and device end
`timescale 1ns/100ps
`default_nettype none
interface cpd_link_if;
  logic [7:0] h2d_data;
  logic       h2d_valid;
  logic       h2d_last;
  logic       h2d_ready;
  logic       nmt_start;
  logic       poll;
  logic [7:0] d2h_data;
  logic       d2h_valid;
  logic       d2h_last;
  logic       d2h_ready;
  modport dev (input h2d_data, h2d_valid, h2d_last, nmt_start, poll, d2h_ready,
               output h2d_ready, d2h_data, d2h_valid, d2h_last);
  modport host (output h2d_data, h2d_valid, h2d_last, nmt_start, poll, d2h_ready,
                input h2d_ready, d2h_data, d2h_valid, d2h_last);
endinterface
`default_nettype wire

/* rtl/cpd_device.sv */
// device end: switch decode, fifo and process data mapping
`timescale 1ns/100ps
`default_nettype none
module cpd_device #(
  parameter int          FLASH_HALF = cpd_pkg::FLASH_HALF_CYC,
  parameter bit          INPUT_ONLY = 1'b0,
  parameter int          FIFO_DEPTH = 4
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  cpd_link_if.dev                         link,
  input  wire logic [cpd_pkg::NODE_W-1:0] node_id_switch_bank_i,
  input  wire logic [cpd_pkg::CFG_W-1:0]  link_config_switch_bank_i,
  input  wire logic [47:0]                status_words_i,
  input  wire logic [7:0]                 digital_input_byte_i,
  input  wire logic                       drive_ready_i,
  output logic [cpd_pkg::NODE_W-1:0]      node_address_o,
  output logic [1:0]                      baud_code_o,
  output logic                            config_valid_o,
  output logic                            operational_o,
  output logic [15:0]                     drive_word_o,
  output logic [1:0]                      drive_word_idx_o,
  output logic                            drive_word_valid_o,
  output logic [7:0]                      digital_output_o,
  output logic                            traffic_indicator_o,
  output logic                            lifetime_indicator_o,
  output logic                            network_status_indicator_o,
  output logic                            system_fault_indicator_o
);
  import cpd_pkg::*;
  logic [NODE_W-1:0] node_s1, node_s2;
  logic [CFG_W-1:0]  cfg_s1, cfg_s2;
  logic [7:0]        di_s1, di_s2;
  cpd_state_t        state, next_state;
  logic [1:0]        wait_cnt, next_wait_cnt;
  logic [1:0]        pd_code, next_pd_code;
  logic              io_en, next_io_en;
  logic [31:0]       flash_cnt, next_flash_cnt;
  logic              flash, next_flash;
  logic [LEN_W-1:0]  rx_pos, next_rx_pos;
  logic [7:0]        word_lo, next_word_lo;
  logic [LEN_W-1:0]  tx_pos, next_tx_pos;
  logic              traffic, next_traffic;
  logic [NODE_W-1:0] next_node;
  logic [1:0]        next_baud;
  logic [15:0]       next_word;
  logic [1:0]        next_word_idx;
  logic              next_word_valid;
  logic [7:0]        next_dout;
  logic [7:0]        next_tx_data;
  logic              next_tx_valid, next_tx_last;
  logic [1:0]        words;
  logic [LEN_W-1:0]  in_len;
  logic              io_out;
  logic [8:0]        f_data;
  logic              f_valid, f_ready;
  logic              pop;

  // fifo holds byte plus end-of-frame flag
  cpd_fifo #(.W(BYTE_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_data_i   ({link.h2d_last, link.h2d_data}),
    .in_valid_i  (link.h2d_valid),
    .in_ready_o  (link.h2d_ready),
    .out_data_o  (f_data),
    .out_valid_o (f_valid),
    .out_ready_i (f_ready)
  );

  // two-stage synchronisers for pins
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      node_s1 <= '0;
      node_s2 <= '0;
      cfg_s1  <= '0;
      cfg_s2  <= '0;
      di_s1   <= '0;
      di_s2   <= '0;
    end
    else if (ce_i)
    begin
      node_s1 <= node_id_switch_bank_i;
      node_s2 <= node_s1;
      cfg_s1  <= link_config_switch_bank_i;
      cfg_s2  <= cfg_s1;
      di_s1   <= digital_input_byte_i;
      di_s2   <= di_s1;
    end
  end

  always_comb
  begin
    words   = cpd_words(pd_code);
    in_len  = cpd_len(words, io_en);
    // input-only variant has no output I/O byte
    io_out  = io_en && !INPUT_ONLY;
    // outside operational state bytes are dropped
    f_ready = (state != CPD_ST_OPER) || !drive_word_valid_o || drive_ready_i;
    pop     = f_valid && f_ready && (state == CPD_ST_OPER);
    next_state      = state;
    next_wait_cnt   = wait_cnt;
    next_node       = node_address_o;
    next_baud       = baud_code_o;
    next_pd_code    = pd_code;
    next_io_en      = io_en;
    next_flash_cnt  = flash_cnt + 32'h1;
    next_flash      = flash;
    next_rx_pos     = rx_pos;
    next_word_lo    = word_lo;
    next_word       = drive_word_o;
    next_word_idx   = drive_word_idx_o;
    next_word_valid = drive_word_valid_o && !drive_ready_i;
    next_dout       = digital_output_o;
    next_tx_pos     = tx_pos;
    next_tx_data    = link.d2h_data;
    next_tx_valid   = link.d2h_valid;
    next_tx_last    = link.d2h_last;
    next_traffic    = 1'b0;
    if (flash_cnt >= 32'(FLASH_HALF - 1))
    begin
      next_flash_cnt = '0;
      next_flash     = !flash;
    end
    case (state)
      CPD_ST_SYNC:
      begin
        next_wait_cnt = wait_cnt + 2'h1;
        if (wait_cnt == 2'(SYNC_STAGES))
        begin
          next_node    = node_s2;
          next_baud    = cfg_s2[BAUD_LSB +: 2];
          next_pd_code = cfg_s2[PD_LSB +: 2];
          next_io_en   = cfg_s2[IO_EN_BIT];
          // zero address or bad length refused
          if (node_s2 == NODE_INVALID || cfg_s2[PD_LSB +: 2] == PD_CODE_BAD)
            next_state = CPD_ST_FAULT;
          else
            next_state = CPD_ST_PREOP;
        end
      end
      CPD_ST_FAULT:
        next_state = CPD_ST_FAULT;
      CPD_ST_PREOP:
      begin
        if (link.nmt_start)
          next_state = CPD_ST_OPER;
      end
      CPD_ST_OPER:
      begin
        if (pop)
        begin
          next_traffic = 1'b1;
          next_rx_pos  = f_data[BYTE_W] ? '0 : rx_pos + LEN_W'(1);
          // low byte first, high byte completes
          if (rx_pos < LEN_W'({words, 1'b0}))
          begin
            if (!rx_pos[0])
              next_word_lo = f_data[7:0];
            else
            begin
              next_word       = {f_data[7:0], word_lo};
              next_word_idx   = rx_pos[2:1];
              next_word_valid = 1'b1;
            end
          end
          else if (rx_pos == LEN_W'({words, 1'b0}) && io_out)
            next_dout = f_data[7:0];
        end
        if (link.d2h_valid && link.d2h_ready)
        begin
          next_traffic = 1'b1;
          next_tx_pos  = tx_pos + LEN_W'(1);
          next_tx_data = cpd_pick(tx_pos + LEN_W'(1), words, status_words_i, di_s2);
          next_tx_last = (tx_pos + LEN_W'(2) == in_len);
          next_tx_valid = !link.d2h_last;
        end
        // input frame of full length on poll
        else if (!link.d2h_valid && link.poll && in_len != '0)
        begin
          next_tx_pos   = '0;
          next_tx_data  = cpd_pick('0, words, status_words_i, di_s2);
          next_tx_last  = (in_len == LEN_W'(1));
          next_tx_valid = 1'b1;
        end
      end
      default:
        next_state = CPD_ST_SYNC;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state                      <= CPD_ST_SYNC;
      wait_cnt                   <= '0;
      node_address_o             <= '0;
      baud_code_o                <= BAUD_125K;
      pd_code                    <= PD_CODE_0;
      io_en                      <= 1'b0;
      flash_cnt                  <= '0;
      flash                      <= 1'b0;
      rx_pos                     <= '0;
      word_lo                    <= '0;
      drive_word_o               <= '0;
      drive_word_idx_o           <= '0;
      drive_word_valid_o         <= 1'b0;
      digital_output_o           <= '0;
      tx_pos                     <= '0;
      link.d2h_data              <= '0;
      link.d2h_valid             <= 1'b0;
      link.d2h_last              <= 1'b0;
      traffic                    <= 1'b0;
      config_valid_o             <= 1'b0;
      operational_o              <= 1'b0;
      traffic_indicator_o        <= 1'b0;
      lifetime_indicator_o       <= 1'b0;
      network_status_indicator_o <= 1'b0;
      system_fault_indicator_o   <= 1'b1;
    end
    else if (ce_i)
    begin
      state              <= next_state;
      wait_cnt           <= next_wait_cnt;
      node_address_o     <= next_node;
      baud_code_o        <= next_baud;
      pd_code            <= next_pd_code;
      io_en              <= next_io_en;
      flash_cnt          <= next_flash_cnt;
      flash              <= next_flash;
      rx_pos             <= next_rx_pos;
      word_lo            <= next_word_lo;
      drive_word_o       <= next_word;
      drive_word_idx_o   <= next_word_idx;
      drive_word_valid_o <= next_word_valid;
      digital_output_o   <= next_dout;
      tx_pos             <= next_tx_pos;
      link.d2h_data      <= next_tx_data;
      link.d2h_valid     <= next_tx_valid;
      link.d2h_last      <= next_tx_last;
      traffic            <= next_traffic;
      config_valid_o     <= (state == CPD_ST_PREOP) || (state == CPD_ST_OPER);
      operational_o      <= (state == CPD_ST_OPER);
      traffic_indicator_o        <= (state == CPD_ST_FAULT) ? flash : traffic;
      lifetime_indicator_o       <= (state == CPD_ST_FAULT) && flash;
      network_status_indicator_o <= (state == CPD_ST_OPER) ||
                                    ((state != CPD_ST_SYNC) && flash);
      system_fault_indicator_o   <= (state == CPD_ST_SYNC) || (state == CPD_ST_FAULT);
    end
  end
endmodule
`default_nettype wire

/* rtl/cpd_host.sv */
// bus master end: start, output frames, input polls; link fifo
`timescale 1ns/100ps
`default_nettype none
module cpd_host #(
  parameter bit INPUT_ONLY = 1'b0
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  cpd_link_if.host         link,
  input  wire logic [1:0]  pd_code_i,
  input  wire logic        io_en_i,
  input  wire logic        start_i,
  input  wire logic        send_i,
  input  wire logic [47:0] out_words_i,
  input  wire logic [7:0]  out_io_i,
  input  wire logic        poll_i,
  output logic             busy_o,
  output logic [47:0]      in_words_o,
  output logic [7:0]       in_io_o,
  output logic             in_done_o
);
  import cpd_pkg::*;
  logic [1:0]       words;
  logic [LEN_W-1:0] out_len;
  logic [LEN_W-1:0] in_len;
  logic [LEN_W-1:0] tx_pos, next_tx_pos;
  logic [LEN_W-1:0] rx_pos, next_rx_pos;
  logic [47:0]      hold_w, next_hold_w;
  logic [7:0]       hold_io, next_hold_io;
  logic [7:0]       next_data;
  logic             next_valid, next_last;
  logic [47:0]      next_in_words;
  logic [7:0]       next_in_io;
  logic             next_done;

  always_comb
  begin
    words         = cpd_words(pd_code_i);
    // input-only variant sends no I/O byte
    out_len       = cpd_len(words, io_en_i && !INPUT_ONLY);
    in_len        = cpd_len(words, io_en_i);
    next_tx_pos   = tx_pos;
    next_hold_w   = hold_w;
    next_hold_io  = hold_io;
    next_data     = link.h2d_data;
    next_valid    = link.h2d_valid;
    next_last     = link.h2d_last;
    next_rx_pos   = rx_pos;
    next_in_words = in_words_o;
    next_in_io    = in_io_o;
    next_done     = 1'b0;
    if (link.h2d_valid && link.h2d_ready)
    begin
      next_tx_pos = tx_pos + LEN_W'(1);
      next_data   = cpd_pick(tx_pos + LEN_W'(1), words, hold_w, hold_io);
      next_last   = (tx_pos + LEN_W'(2) == out_len);
      next_valid  = !link.h2d_last;
    end
    else if (!link.h2d_valid && send_i && out_len != '0)
    begin
      next_hold_w  = out_words_i;
      next_hold_io = out_io_i;
      next_tx_pos  = '0;
      next_data    = cpd_pick('0, words, out_words_i, out_io_i);
      next_last    = (out_len == LEN_W'(1));
      next_valid   = 1'b1;
    end
    if (link.d2h_valid)
    begin
      // collect words then the I/O byte
      if (rx_pos < LEN_W'({words, 1'b0}))
        next_in_words[{rx_pos[2:1], 4'h0} + {rx_pos[0], 3'h0} +: 8] = link.d2h_data;
      else
        next_in_io = link.d2h_data;
      next_rx_pos = link.d2h_last ? '0 : rx_pos + LEN_W'(1);
      next_done   = link.d2h_last;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_pos         <= '0;
      hold_w         <= '0;
      hold_io        <= '0;
      link.h2d_data  <= '0;
      link.h2d_valid <= 1'b0;
      link.h2d_last  <= 1'b0;
      link.nmt_start <= 1'b0;
      link.poll      <= 1'b0;
      link.d2h_ready <= 1'b0;
      rx_pos         <= '0;
      in_words_o     <= '0;
      in_io_o        <= '0;
      in_done_o      <= 1'b0;
      busy_o         <= 1'b0;
    end
    else if (ce_i)
    begin
      tx_pos         <= next_tx_pos;
      hold_w         <= next_hold_w;
      hold_io        <= next_hold_io;
      link.h2d_data  <= next_data;
      link.h2d_valid <= next_valid;
      link.h2d_last  <= next_last;
      link.nmt_start <= start_i;
      link.poll      <= poll_i;
      link.d2h_ready <= 1'b1;
      rx_pos         <= next_rx_pos;
      in_words_o     <= next_in_words;
      in_io_o        <= next_in_io;
      in_done_o      <= next_done;
      busy_o         <= next_valid;
    end
  end
endmodule

module cpd_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 4
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  import cpd_pkg::*;
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [CW-1:0] next_count;
  logic          push;
  logic          pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  always_comb
  begin
    in_ready_o  = (count != CW'(DEPTH));
    out_valid_o = (count != '0);
    out_data_o  = mem[rd_ptr];
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
    next_count  = count + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else if (ce_i)
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (ce_i && push)
      mem[wr_ptr] <= in_data_i;
  end
endmodule
`default_nettype wire

/* tb/cpd_link_monitor.sv */
// checker for the process data byte link
`timescale 1ns/100ps
`default_nettype none
module cpd_link_monitor (
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_valid,
  input wire logic       h2d_last,
  input wire logic       h2d_ready,
  input wire logic       nmt_start,
  input wire logic       poll,
  input wire logic [7:0] d2h_data,
  input wire logic       d2h_valid,
  input wire logic       d2h_last,
  input wire logic       d2h_ready
);
  import cpd_pkg::*;
  logic [3:0] h_cnt;
  logic [3:0] d_cnt;
  wire logic  h_take = h2d_valid && h2d_ready;
  wire logic  d_take = d2h_valid && d2h_ready;
  // bytes taken so far in the current frame
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      h_cnt <= 4'h0;
      d_cnt <= 4'h0;
    end
    else
    begin
      if (h_take)
        h_cnt <= h2d_last ? 4'h0 : h_cnt + 4'h1;
      if (d_take)
        d_cnt <= d2h_last ? 4'h0 : d_cnt + 4'h1;
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  sequence poll_s;
    poll && !d2h_valid;
  endsequence
  sequence last_s;
    h_take && h2d_last;
  endsequence
  h2d_hold_a:
    assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable({h2d_data, h2d_last}))
    else $error("output byte changed before taken");
  d2h_hold_a:
    assert property (d2h_valid && !d2h_ready |=> d2h_valid && $stable({d2h_data, d2h_last}))
    else $error("input byte changed before taken");
  h2d_len_a:
    assert property (h_take && h2d_last |-> (h_cnt + 4'h1) inside {4'h1, 4'h4, 4'h5, 4'h6, 4'h7})
    else $error("output frame length wrong");
  d2h_len_a:
    assert property (d_take && d2h_last |-> (d_cnt + 4'h1) inside {4'h1, 4'h4, 4'h5, 4'h6, 4'h7})
    else $error("input frame length wrong");
  poll_reply_a:
    assert property (poll_s |=> d2h_valid)
    else $error("no input byte after poll");
  frame_end_a:
    assert property (last_s |=> !h2d_valid)
    else $error("output valid after last byte");
  ready_hold_a:
    assert property (d2h_ready |=> d2h_ready)
    else $error("host ready dropped");
  start_pulse_a:
    assert property (nmt_start |=> !nmt_start ##1 !nmt_start)
    else $error("start request longer than a pulse");
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for both link ends
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tb;
  import cpd_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [6:0]  node = 7'h09;
  logic [5:0]  cfg = 6'h1D;
  logic [47:0] sw = 48'hA1B2C3D4E5F6;
  logic [47:0] ow = 48'h123456789ABC;
  logic [7:0]  din = 8'h5A;
  logic [7:0]  oio = 8'hC3;
  logic        drdy = 1'b1;
  logic        start = 1'b0;
  logic        send = 1'b0;
  logic        pll = 1'b0;
  logic        full = 1'b0;
  logic        ce = 1'b1;
  logic [6:0]  naddr;
  logic [1:0]  baud, didx;
  logic        cval, oper, dwv, trf, life, net, sysf, busy, done;
  logic [15:0] dw;
  logic [7:0]  dout, iio;
  logic [47:0] iw;
  logic [15:0] drw [3];
  logic [7:0]  hb [8];
  logic [7:0]  db [8];
  int          hn, dn, dcount, bad_count, num_checks;
  always #2.5 clk_sys_i = ~clk_sys_i;
  cpd_link_if lnk ();
  cpd_device #(.FLASH_HALF(4)) i_cpd_device (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .ce_i(ce), .link(lnk.dev), .node_id_switch_bank_i(node),
    .link_config_switch_bank_i(cfg), .status_words_i(sw), .digital_input_byte_i(din),
    .drive_ready_i(drdy), .node_address_o(naddr), .baud_code_o(baud),
    .config_valid_o(cval), .operational_o(oper), .drive_word_o(dw),
    .drive_word_idx_o(didx), .drive_word_valid_o(dwv), .digital_output_o(dout),
    .traffic_indicator_o(trf), .lifetime_indicator_o(life),
    .network_status_indicator_o(net), .system_fault_indicator_o(sysf));
  cpd_host i_cpd_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce), .link(lnk.host),
    .pd_code_i(cfg[3:2]), .io_en_i(cfg[4]), .start_i(start), .send_i(send),
    .out_words_i(ow), .out_io_i(oio), .poll_i(pll), .busy_o(busy), .in_words_o(iw),
    .in_io_o(iio), .in_done_o(done));
  cpd_link_monitor i_cpd_link_monitor (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .h2d_data(lnk.h2d_data), .h2d_valid(lnk.h2d_valid), .h2d_last(lnk.h2d_last),
    .h2d_ready(lnk.h2d_ready), .nmt_start(lnk.nmt_start), .poll(lnk.poll),
    .d2h_data(lnk.d2h_data), .d2h_valid(lnk.d2h_valid), .d2h_last(lnk.d2h_last),
    .d2h_ready(lnk.d2h_ready));
  // capture of wire bytes and drive words
  always @(posedge clk_sys_i)
  begin
    if (dwv === 1'b1 && drdy)
    begin
      drw[didx] <= dw;
      dcount <= dcount + 1;
    end
    if (lnk.h2d_valid === 1'b1 && lnk.h2d_ready === 1'b1)
    begin
      hb[hn % 8] <= lnk.h2d_data;
      hn <= hn + 1;
    end
    if (lnk.d2h_valid === 1'b1 && lnk.d2h_ready === 1'b1)
    begin
      db[dn % 8] <= lnk.d2h_data;
      dn <= dn + 1;
    end
    if (lnk.h2d_ready === 1'b0 && !rst_i)
      full <= 1'b1;
  end
  task automatic setup(input logic [6:0] n, input logic [5:0] c);
    node = n;
    cfg = c;
    rst_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (8) @(negedge clk_sys_i);
  endtask
  task automatic flash(output logic [2:0] chg);
    logic [2:0] p;
    chg = 3'h0;
    p = {trf, life, net};
    repeat (12)
    begin
      @(negedge clk_sys_i);
      chg = chg | (p ^ {trf, life, net});
      p = {trf, life, net};
    end
  endtask
  task automatic frame(input int stall);
    drdy = (stall == 0);
    full = 1'b0;
    hn = 0;
    dcount = 0;
    send = 1'b1;
    @(negedge clk_sys_i);
    send = 1'b0;
    for (int k = 0; k < 300 && (busy !== 1'b0 || k < 60); k++)
    begin
      @(negedge clk_sys_i);
      if (k == stall)
        drdy = 1'b1;
    end
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #50000;
    bad_count++;
    give_verdict();
  end
  initial
  begin
    logic [2:0] chg;
    logic [5:0] cfgs [3];
    logic [6:0] n;
    int w;
    cfgs = '{6'h1D, 6'h08, 6'h10};
    setup(7'h00, 6'h1C);
    `CHK("valid", 1'b0, cval)
    `CHK("sysf", 1'b1, sysf)
    flash(chg);
    `CHK("flash", 3'h7, chg)
    ce = 1'b0;
    flash(chg);
    `CHK("freeze", 3'h0, chg)
    ce = 1'b1;
    setup(7'h09, 6'h04);
    `CHK("valid", 1'b0, cval)
    for (int b = 0; b < 4; b++)
    begin
      n = (b == 3) ? 7'h40 : 7'h7F >> (2 * b);
      setup(n, {4'h3, 2'(b)});
      `CHK("addr", n, naddr)
      `CHK("baud", 2'(b), baud)
      `CHK("valid", 1'b1, cval)
      `CHK("sysf", 1'b0, sysf)
    end
    foreach (cfgs[i])
    begin
      ow = ~ow;
      sw = ~sw;
      din = ~din;
      oio = ~oio;
      w = (cfgs[i][3:2] == 2'h3) ? 3 : (cfgs[i][3:2] == 2'h2) ? 2 : 0;
      setup(7'h09, cfgs[i]);
      flash(chg);
      `CHK("preop", 3'h1, chg)
      frame(0);
      `CHK("drop", 0, dcount)
      node = 7'h22;
      cfg[1:0] = ~cfg[1:0];
      start = 1'b1;
      @(negedge clk_sys_i);
      start = 1'b0;
      repeat (4) @(negedge clk_sys_i);
      `CHK("oper", 1'b1, oper)
      `CHK("net", 1'b1, net)
      `CHK("addr", 7'h09, naddr)
      `CHK("baud", cfgs[i][1:0], baud)
      frame((w == 3) ? 40 : 0);
      if (w == 3)
        `CHK("full", 1'b1, full)
      `CHK("hn", 2 * w + cfgs[i][4], hn)
      for (int k = 0; k < 2 * w; k++)
        `CHK("hb", ow[8 * k +: 8], hb[k])
      for (int k = 0; k < w; k++)
        `CHK("drw", ow[16 * k +: 16], drw[k])
      dn = 0;
      pll = 1'b1;
      @(negedge clk_sys_i);
      pll = 1'b0;
      for (int k = 0; k < 60 && done !== 1'b1; k++) @(negedge clk_sys_i);
      `CHK("dn", 2 * w + cfgs[i][4], dn)
      for (int k = 0; k < 2 * w; k++)
        `CHK("db", sw[8 * k +: 8], db[k])
      for (int k = 0; k < w; k++)
        `CHK("iw", sw[16 * k +: 16], iw[16 * k +: 16])
      if (cfgs[i][4])
      begin
        `CHK("hio", oio, hb[2 * w])
        `CHK("dio", din, db[2 * w])
        `CHK("dout", oio, dout)
        `CHK("iio", din, iio)
      end
    end
    give_verdict();
  end
endmodule
`default_nettype wire
